// File: verilog/dma_err_pace.sv
`timescale 1ns/1ps
`include "dma_err_pace_defines.svh"

module dma_err_pace (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          clk_en,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [11:0]                   paddr,
   input  wire logic [31:0]                   pwdata,
   output      logic [31:0]                   prdata,
   output      logic                          pready,
   output      logic                          pslverr,
   input  wire logic                          req_valid,
   input  wire dma_err_pace_pkg::request_t    req,
   output      logic                          req_ready,
   input  wire logic                          rd_done,
   input  wire logic                          rd_want,
   output      logic                          rd_cmd,
   output      logic [31:0]                   rd_cmd_addr,
   input  wire dma_err_pace_pkg::bus_status_t rd_status,
   input  wire dma_err_pace_pkg::bus_status_t wr_status,
   output      logic                          err_irq
);
   import dma_err_pace_pkg::*;

   state_t      s;
   state_t      n;
   logic        apb_go;
   logic        apb_wr;
   logic        mapped;
   logic [31:0] rdata;
   logic [3:0]  set_v;
   logic [3:0]  clr_v;
   logic [3:0]  rise_v;
   logic        evaluate_bit_hit;
   logic        req_bad;
   logic        bus_evt;
   bus_status_t pick;
   logic [5:0]  width_bytes;
   logic [5:0]  idle_cycles;
   logic [5:0]  off_step;

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign prdata      = s.prdata;
   assign pready      = s.pready;
   assign pslverr     = s.pslverr;
   assign req_ready   = s.req_ready;
   assign rd_cmd      = s.rd_cmd;
   assign rd_cmd_addr = s.rd_addr;
   assign err_irq     = s.irq;

   // ------------------------------------------------------------------
   // apb decode and read mux
   // ------------------------------------------------------------------
   // one wait state: pready rises the cycle after the access phase opens
   always_comb
   begin
      apb_go = psel && penable && !s.pready;
      apb_wr = psel && penable && s.pready && pwrite && !s.pslverr;
      mapped = 1'b1;
      rdata  = 32'h0000_0000;
      case (paddr)
         `OFS_STATUS:
            rdata[3:0] = s.flags;
         `OFS_ENABLE:
            rdata[3:0] = s.enable;
         `OFS_CLEAR,
         `OFS_REEVAL:
            rdata = 32'h0000_0000;
         `OFS_DETAILS:
         begin
            rdata[`DET_CHAIN] = s.det_tag.chain_en;
            rdata[`DET_IRQ]   = s.det_tag.irq_en;
            rdata[`DET_CODE_HI:`DET_CODE_LO] = s.det_tag.completion_code;
            rdata[`DET_STAT_HI:0] = s.det_stat;
         end
         `OFS_SPACING:
            rdata[`SPACE_HI:0] = s.spacing;
         `OFS_ACT_OPTS:
         begin
            rdata[`OPT_CHAIN] = s.act_tag.chain_en;
            rdata[`OPT_IRQ]   = s.act_tag.irq_en;
            rdata[`OPT_CODE_HI:`OPT_CODE_LO] = s.act_tag.completion_code;
            rdata[`OPT_FIFO_WIDTH_SELECT_HI:`OPT_FIFO_WIDTH_SELECT_LO] = s.act_fifo_width_select;
            rdata[`OPT_PRI_HI:`OPT_PRI_LO] = s.act_pri;
            rdata[`OPT_DAM] = s.act_dam;
            rdata[`OPT_SAM] = s.act_sam;
         end
         default:
            mapped = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------
   // error event sources
   // ------------------------------------------------------------------
   // fifo width in bytes, used for alignment checks and offset wrap
   always_comb
   begin
      width_bytes = 6'd1 << req.fifo_width_select;
      if (s.active)
      begin
         width_bytes = 6'd1 << s.act_fifo_width_select;
      end
      // zero counts or misaligned constant addressing
      req_bad = (req.first_dim_count == 16'h0000)
             || (req.second_dim_count == 16'h0000);
      // width checked only when a constant mode is selected
      if (req.source_constant_mode || req.destination_constant_mode)
      begin
         req_bad = req_bad
                || (req.fifo_width_select > `FIFO_WIDTH_SELECT_MAX)
                || ((req.src_addr[5:0] & (width_bytes - 6'd1)) != 6'd0)
                || ((req.dst_addr[5:0] & (width_bytes - 6'd1)) != 6'd0)
                || ((req.first_dim_count[5:0] & (width_bytes - 6'd1))
                    != 6'd0);
      end
      // nonzero status wins, write beats read when both fail
      bus_evt = (rd_status.code != 4'h0) || (wr_status.code != 4'h0);
      pick    = (wr_status.code != 4'h0) ? wr_status : rd_status;
      set_v   = 4'h0;
      set_v[`BIT_MAP_ERR] = apb_go && !mapped;
      set_v[`BIT_REQ_ERR] = req_valid && s.req_ready && req_bad;
      set_v[`BIT_BUS_ERR] = bus_evt;
      clr_v = 4'h0;
      evaluate_bit_hit = 1'b0;
      if (apb_wr && (paddr == `OFS_CLEAR))
      begin
         clr_v = pwdata[3:0] & `FLAG_MASK;
      end
      if (apb_wr && (paddr == `OFS_REEVAL))
      begin
         evaluate_bit_hit = pwdata[`BIT_EVALUATE_BIT];
      end
      // only enabled flags that were clear or are being cleared count as a rise
      rise_v = set_v & ~(s.flags & ~clr_v) & s.enable;
   end

   // ------------------------------------------------------------------
   // read pacing step sizes
   // ------------------------------------------------------------------
   // spacing code to cycles; reserved codes run back-to-back
   always_comb
   begin
      case (s.spacing)
         3'h1:    idle_cycles = `SPACE_CYC_1 - 6'd1;
         3'h2:    idle_cycles = `SPACE_CYC_2 - 6'd1;
         3'h3:    idle_cycles = `SPACE_CYC_3 - 6'd1;
         3'h4:    idle_cycles = `SPACE_CYC_4 - 6'd1;
         default: idle_cycles = 6'd0;
      endcase
      off_step = s.src_off + `BEAT_BYTES;
   end

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb
   begin
      n         = s;
      n.rd_cmd  = 1'b0;
      n.irq     = 1'b0;
      n.pready  = apb_go;
      if (apb_go)
      begin
         n.prdata  = rdata;
         n.pslverr = !mapped;
      end
      else
      begin
         n.pslverr = 1'b0;
      end

      // enable register; bit 1 never stored
      if (apb_wr && (paddr == `OFS_ENABLE))
      begin
         n.enable = pwdata[3:0] & `FLAG_MASK;
      end
      // one global spacing for every request
      if (apb_wr && (paddr == `OFS_SPACING))
      begin
         n.spacing = pwdata[`SPACE_HI:0];
      end

      // clear by write-one, a same-cycle event wins
      n.flags = ((s.flags & ~clr_v) | set_v) & `FLAG_MASK;

      if (clr_v[`BIT_BUS_ERR])
      begin
         n.det_tag  = '0;
         n.det_stat = 4'h0;
      end
      // capture only when the bus flag is clear or being cleared
      if (bus_evt && (!s.flags[`BIT_BUS_ERR] || clr_v[`BIT_BUS_ERR]))
      begin
         n.det_tag  = pick.tag;
         n.det_stat = pick.code;
      end

      // pulse on a new enabled flag or on evaluate with an enabled flag set
      if ((rise_v != 4'h0)
          || (evaluate_bit_hit && ((s.flags & s.enable) != 4'h0)))
      begin
         n.irq = 1'b1;
      end

      // active set loaded only from an accepted request
      if (req_valid && s.req_ready && !req_bad)
      begin
         n.active   = 1'b1;
         n.act_tag  = req.tag;
         n.act_fifo_width_select = req.fifo_width_select;
         n.act_pri  = req.transfer_priority;
         n.act_sam  = req.source_constant_mode;
         n.act_dam  = req.destination_constant_mode;
         n.src_base = req.src_addr;
         n.src_off  = 6'd0;
      end
      else if (rd_done)
      begin
         n.active = 1'b0;
      end

      // gap counts the idle cycles after each read command
      case (s.pace)
         PACE_IDLE:
         begin
            if (s.active && rd_want && !rd_done)
            begin
               n.rd_cmd  = 1'b1;
               n.rd_addr = s.src_base + {26'h000_0000, s.src_off};
               // constant mode wraps at the fifo width
               if (s.act_sam && (off_step >= width_bytes))
               begin
                  n.src_off = 6'd0;
               end
               else
               begin
                  n.src_off = off_step;
               end
               if (idle_cycles != 6'd0)
               begin
                  n.pace = PACE_GAP;
                  n.gap  = idle_cycles;
               end
            end
         end
         PACE_GAP:
         begin
            if (s.gap <= 6'd1)
            begin
               n.pace = PACE_IDLE;
               n.gap  = 6'd0;
            end
            else
            begin
               n.gap = s.gap - 6'd1;
            end
         end
         default:
         begin
            n.pace = PACE_IDLE;
            n.gap  = 6'd0;
         end
      endcase
      n.req_ready = !n.active;
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   // clk_en low freezes every bit, including the apb handshake
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s           <= '0;
         s.flags     <= `FLAG_RESET;
         s.enable    <= `ENABLE_RESET;
         s.spacing   <= `SPACE_RESET;
         s.pace      <= PACE_IDLE;
         s.req_ready <= 1'b1;
      end
      else if (clk_en)
      begin
         s <= n;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   // ce cycles since the last read command, saturating
   logic [5:0] gap_seen;
   logic       first_cmd;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gap_seen  <= 6'd0;
         first_cmd <= 1'b1;
      end
      else if (clk_en)
      begin
         if (rd_cmd)
         begin
            gap_seen  <= 6'd0;
            first_cmd <= 1'b0;
         end
         else if (gap_seen != 6'h3F)
         begin
            gap_seen <= gap_seen + 6'd1;
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence clear_write_s;
      clk_en && psel && penable && pready && pwrite && !pslverr
      && (paddr == `OFS_CLEAR);
   endsequence

   sequence reeval_write_s;
      clk_en && psel && penable && pready && pwrite && !pslverr
      && (paddr == `OFS_REEVAL) && pwdata[`BIT_EVALUATE_BIT];
   endsequence

   irq_one_cycle_a: assert property (
      (err_irq && clk_en) |=> !err_irq)
      else $error("error interrupt held longer than one cycle");

   enable_bit1_a: assert property (
      s.enable[1] == 1'b0)
      else $error("reserved enable bit stored");

   bus_clear_a: assert property (
      (clear_write_s ##0 pwdata[`BIT_BUS_ERR] && !bus_evt)
      |=> (!s.flags[`BIT_BUS_ERR] && (s.det_stat == 4'h0)))
      else $error("bus error clear left flag or details");

   map_clear_a: assert property (
      (clear_write_s ##0 pwdata[`BIT_MAP_ERR] && !pwdata[`BIT_BUS_ERR]
       && !bus_evt && !(psel && !mapped))
      |=> (!s.flags[`BIT_MAP_ERR] && $stable(s.det_stat)))
      else $error("map clear wrong or details disturbed");

   write_wins_a: assert property (
      (clk_en && !s.flags[`BIT_BUS_ERR] && (rd_status.code != 4'h0)
       && (wr_status.code != 4'h0))
      |=> (s.det_stat == $past(wr_status.code)))
      else $error("write status did not take priority");

   read_spacing_a: assert property (
      (rd_cmd && !first_cmd && (s.spacing == 3'h2) && clk_en)
      |-> (gap_seen >= 6'd7))
      else $error("read commands closer than programmed spacing");

   req_error_a: assert property (
      (clk_en && req_valid && req_ready && (req.first_dim_count == 16'h0000))
      |=> (s.flags[`BIT_REQ_ERR] && req_ready))
      else $error("zero count request not flagged");

   reeval_pulse_a: assert property (
      (reeval_write_s ##0 ((s.flags & s.enable) != 4'h0)) |=> err_irq)
      else $error("evaluate did not re-pulse the error line");

   prio_reflect_a: assert property (
      (clk_en && req_valid && req_ready && !req_bad)
      |=> (s.act_pri == $past(req.transfer_priority)))
      else $error("active priority does not mirror the request");

endmodule : dma_err_pace

// File: verilog/dma_err_pace_defines.svh
`ifndef DMA_ERR_PACE_DEFINES_SVH
`define DMA_ERR_PACE_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_STATUS      12'h000
`define OFS_ENABLE      12'h004
`define OFS_CLEAR       12'h008
`define OFS_DETAILS     12'h00C
`define OFS_REEVAL      12'h010
`define OFS_SPACING     12'h014
`define OFS_ACT_OPTS    12'h018

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_MAP_ERR     3
`define BIT_REQ_ERR     2
`define BIT_BUS_ERR     0
`define BIT_EVALUATE_BIT        0
`define DET_CHAIN       17
`define DET_IRQ         16
`define DET_CODE_HI     13
`define DET_CODE_LO     8
`define DET_STAT_HI     3
`define OPT_CHAIN       22
`define OPT_IRQ         20
`define OPT_CODE_HI     17
`define OPT_CODE_LO     12
`define OPT_FIFO_WIDTH_SELECT_HI     10
`define OPT_FIFO_WIDTH_SELECT_LO     8
`define OPT_PRI_HI      6
`define OPT_PRI_LO      4
`define OPT_DAM         1
`define OPT_SAM         0
`define SPACE_HI        2

// ----------------------------------------------------------------------
// masks, limits and reset values
// ----------------------------------------------------------------------
`define FLAG_MASK       4'hD
`define FLAG_RESET      4'h0
`define ENABLE_RESET    4'h0
`define SPACE_RESET     3'h0
`define FIFO_WIDTH_SELECT_MAX        3'h5

// ----------------------------------------------------------------------
// read spacing in cycles between read commands, and read address step in bytes
// ----------------------------------------------------------------------
`define SPACE_CYC_1     6'd4
`define SPACE_CYC_2     6'd8
`define SPACE_CYC_3     6'd16
`define SPACE_CYC_4     6'd32
`define BEAT_BYTES      6'd4

`endif

// File: verilog/dma_err_pace_pkg.sv
package dma_err_pace_pkg;

   // completion options carried with a request or a failing transaction
   typedef struct packed {
      logic       chain_en;
      logic       irq_en;
      logic [5:0] completion_code;
   } completion_tag_t;

   // transfer request from the channel controller
   typedef struct packed {
      completion_tag_t tag;
      logic [2:0]      fifo_width_select;
      logic [2:0]      transfer_priority;
      logic            source_constant_mode;
      logic            destination_constant_mode;
      logic [31:0]     src_addr;
      logic [31:0]     dst_addr;
      logic [15:0]     first_dim_count;
      logic [15:0]     second_dim_count;
   } request_t;

   // one status return from the read or write status bus
   typedef struct packed {
      logic [3:0]      code;
      completion_tag_t tag;
   } bus_status_t;

   typedef enum logic [1:0] {
      PACE_IDLE = 2'b01,
      PACE_GAP  = 2'b10
   } pace_state_t;

   // whole register state of the block
   typedef struct packed {
      logic [3:0]      flags;
      logic [3:0]      enable;
      completion_tag_t det_tag;
      logic [3:0]      det_stat;
      logic [2:0]      spacing;
      completion_tag_t act_tag;
      logic [2:0]      act_fifo_width_select;
      logic [2:0]      act_pri;
      logic            act_sam;
      logic            act_dam;
      logic            active;
      logic [31:0]     src_base;
      logic [5:0]      src_off;
      pace_state_t     pace;
      logic [5:0]      gap;
      logic            rd_cmd;
      logic [31:0]     rd_addr;
      logic            irq;
      logic            req_ready;
      logic            pready;
      logic            pslverr;
      logic [31:0]     prdata;
   } state_t;

endpackage : dma_err_pace_pkg

// File: testbench/dma_far_side.sv
`timescale 1ns/1ps
// far side: channel controller plus the read and write endpoints
module dma_far_side
   import dma_err_pace_pkg::*;
(
   input  wire logic                          pclk,
   input  wire logic                          req_ready,
   input  wire logic                          rd_cmd,
   output      logic                          req_valid,
   output      dma_err_pace_pkg::request_t    req,
   output      logic                          rd_want,
   output      logic                          rd_done,
   output      dma_err_pace_pkg::bus_status_t rd_status,
   output      dma_err_pace_pkg::bus_status_t wr_status
);
   // ------------------------------------------------------------
   // idle at time zero, then driven only by the tasks below
   // ------------------------------------------------------------
   initial
   begin
      req_valid = 1'b0;
      req       = '0;
      rd_want   = 1'b0;
      rd_done   = 1'b0;
      rd_status = '0;
      wr_status = '0;
   end

   // offer held until taken or for at most 50 cycles; payload scrambled after release
   task automatic offer(input request_t r, output logic ok);
      int i;
      begin
         req_valid <= 1'b1;
         req       <= r;
         ok = 1'b0;
         for (i = 0; i < 50 && !ok; i++)
         begin
            @(posedge pclk);
            ok = (req_ready === 1'b1);
         end
         req_valid <= 1'b0;
         req       <= ~r;
      end
   endtask : offer

   // hold the read wish for n commands or at most 400 cycles, then end the request
   task automatic fetch(input int n, output logic ok);
      int k;
      int i;
      begin
         k = 0;
         rd_want <= 1'b1;
         for (i = 0; i < 400 && k < n; i++)
         begin
            @(posedge pclk);
            if (rd_cmd === 1'b1)
               k++;
         end
         ok = (k == n);
         rd_want <= 1'b0;
         @(posedge pclk);
         rd_done <= 1'b1;
         @(posedge pclk);
         rd_done <= 1'b0;
      end
   endtask : fetch

   // one-cycle status return; tag is not left standing afterwards
   task automatic fault(input logic [3:0] rc, input logic [3:0] wc,
                        input completion_tag_t t);
      begin
         rd_status <= {rc, t};
         wr_status <= {wc, t};
         @(posedge pclk);
         rd_status <= {4'h0, ~t};
         wr_status <= {4'h0, ~t};
         @(posedge pclk);
      end
   endtask : fault
endmodule : dma_far_side

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`include "dma_err_pace_defines.svh"
module tb_top;
   import dma_err_pace_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam completion_tag_t tag_a = 8'hAA;
   localparam completion_tag_t tag_b = 8'h55;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        clk_en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_cmd_addr;
   logic        req_valid, req_ready, rd_done, rd_want, rd_cmd, err_irq;
   request_t    req;
   bus_status_t rd_status, wr_status;
   int          n_fail, num_checks, cyc, irq_cnt;
   int          cmd_cyc[$];
   logic [31:0] cmd_addr[$];

   always #2 pclk = ~pclk;

   dma_err_pace u_dut (.pclk, .presetn, .clk_en, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .req_valid,
      .req, .req_ready, .rd_done, .rd_want, .rd_cmd, .rd_cmd_addr,
      .rd_status, .wr_status, .err_irq);
   dma_far_side u_far (.pclk, .req_ready, .rd_cmd, .req_valid, .req,
      .rd_want, .rd_done, .rd_status, .wr_status);

   // pulse counting keeps irq checks free of edge races
   always @(posedge pclk)
   begin
      cyc++;
      if (err_irq === 1'b1)
         irq_cnt++;
      if (rd_cmd === 1'b1)
      begin
         cmd_cyc.push_back(cyc);
         cmd_addr.push_back(rd_cmd_addr);
      end
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   task automatic chk(input string nm, input logic [31:0] ex,
                      input logic [31:0] got);
      num_checks++;
      if (got !== ex)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
         n_fail++;
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int i;
      begin
         psel    <= 1'b1;
         penable <= 1'b0;
         pwrite  <= w;
         paddr   <= a;
         pwdata  <= d;
         @(posedge pclk);
         penable <= 1'b1;
         i = 0;
         do
         begin
            @(posedge pclk);
            i++;
         end
         while (pready !== 1'b1 && i < 20);
         if (pready !== 1'b1)
         begin
            $display("MISMATCH pready expected 1 seen timeout");
            n_fail++;
            end_sim;
         end
         q = prdata;
         e = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] ex,
                     input string nm);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(nm, ex, q);
   endtask : rd

   task settle;
      repeat (3) @(posedge pclk);
   endtask : settle

   function automatic logic [31:0] det(completion_tag_t t, logic [3:0] s);
      return {14'h0, t.chain_en, t.irq_en, 2'h0, t.completion_code,
              4'h0, s};
   endfunction : det

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_reset;
      rd(`OFS_STATUS, 32'h0, "status");
      rd(`OFS_DETAILS, 32'h0, "details");
      rd(`OFS_ACT_OPTS, 32'h0, "options");
      rd(`OFS_SPACING, 32'h0, "spacing");
      wr(`OFS_ENABLE, 32'hFFFF_FFFD);
      rd(`OFS_ENABLE, 32'h0000_000D, "enable");
      wr(`OFS_SPACING, 32'hFFFF_FFFF);
      rd(`OFS_SPACING, 32'h0000_0007, "spacing");
   endtask : t_reset

   // bus, map and request errors; map and request errors leave the captured details alone
   task automatic t_errs;
      int          n;
      logic [31:0] q;
      logic        e;
      logic        ok;
      request_t    r;
      n = irq_cnt;
      wr(`OFS_ENABLE, 32'h0000_0001);
      u_far.fault(4'h0, 4'h9, tag_a);
      settle;
      chk("irq", 32'(n + 1), 32'(irq_cnt));
      rd(`OFS_DETAILS, det(tag_a, 4'h9), "details");
      u_far.fault(4'h3, 4'h0, tag_b);
      settle;
      rd(`OFS_DETAILS, det(tag_a, 4'h9), "details");
      chk("irq", 32'(n + 1), 32'(irq_cnt));
      wr(`OFS_REEVAL, 32'h0000_0001);
      settle;
      chk("irq", 32'(n + 2), 32'(irq_cnt));
      wr(`OFS_ENABLE, 32'h0000_000D);
      apb(1'b0, 12'h040, 32'h0, q, e);
      settle;
      chk("slverr", 32'h1, {31'h0, e});
      chk("irq", 32'(n + 3), 32'(irq_cnt));
      u_far.offer('0, ok);
      settle;
      chk("irq", 32'(n + 4), 32'(irq_cnt));
      chk("ready", 32'h1, {31'h0, req_ready});
      rd(`OFS_STATUS, 32'h0000_000D, "status");
      wr(`OFS_CLEAR, 32'h0000_0008);
      rd(`OFS_STATUS, 32'h0000_0005, "status");
      rd(`OFS_DETAILS, det(tag_a, 4'h9), "details");
      wr(`OFS_CLEAR, 32'h0000_0004);
      rd(`OFS_STATUS, 32'h0000_0001, "status");
      rd(`OFS_DETAILS, det(tag_a, 4'h9), "details");
      r = '0;
      r.fifo_width_select = 3'h2;
      r.source_constant_mode = 1'b1;
      r.src_addr = 32'h0000_1001;
      r.first_dim_count = 16'h0004;
      r.second_dim_count = 16'h0001;
      u_far.offer(r, ok);
      rd(`OFS_STATUS, 32'h0000_0005, "status");
      chk("irq", 32'(n + 5), 32'(irq_cnt));
      wr(`OFS_CLEAR, 32'h0000_0004);
      wr(`OFS_CLEAR, 32'h0000_0001);
      rd(`OFS_DETAILS, 32'h0, "details");
      wr(`OFS_ENABLE, 32'h0);
      u_far.fault(4'h1, 4'h0, tag_a);
      wr(`OFS_REEVAL, 32'h0000_0001);
      settle;
      chk("irq", 32'(n + 5), 32'(irq_cnt));
      rd(`OFS_STATUS, 32'h0000_0001, "status");
      wr(`OFS_CLEAR, 32'h0000_0001);
      // a status return while clk_en is low must leave no trace
      clk_en <= 1'b0;
      u_far.fault(4'h1, 4'h0, tag_a);
      clk_en <= 1'b1;
      rd(`OFS_STATUS, 32'h0, "frozen");
   endtask : t_errs

   // every defined code, low codes from the read side and high codes from the write side, then both sides at once
   task automatic t_codes;
      logic [3:0] cs[10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7,
                             4'h9, 4'hA, 4'hB, 4'hC, 4'hF};
      foreach (cs[i])
      begin
         if (cs[i] < 4'h8)
            u_far.fault(cs[i], 4'h0, tag_b);
         else
            u_far.fault(4'h0, cs[i], tag_b);
         rd(`OFS_DETAILS, det(tag_b, cs[i]), "details");
         wr(`OFS_CLEAR, 32'h0000_0001);
      end
      u_far.fault(4'h4, 4'hC, tag_a);
      rd(`OFS_DETAILS, det(tag_a, 4'hC), "details");
      wr(`OFS_CLEAR, 32'h0000_0001);
   endtask : t_codes

   // one request per spacing code 0 to 5; odd codes use constant source and destination
   task automatic t_pace;
      int          gaps[6] = '{1, 4, 8, 16, 32, 1};
      request_t    r;
      logic        ok;
      logic        cm;
      logic [31:0] ex;
      r = '0;
      r.tag = tag_a;
      r.fifo_width_select = 3'h2;
      r.transfer_priority = 3'h5;
      r.src_addr = 32'h0000_1000;
      r.dst_addr = 32'h0000_2000;
      r.first_dim_count = 16'h0010;
      r.second_dim_count = 16'h0002;
      for (int s = 0; s < 6; s++)
      begin
         cm = s[0];
         r.source_constant_mode = cm;
         r.destination_constant_mode = cm;
         ex = {9'h0, 3'b100, 2'h0, 6'h2A, 4'h2, 4'h5, 2'h0, cm, cm};
         wr(`OFS_SPACING, 32'(s));
         u_far.offer(r, ok);
         chk("taken", 32'h1, {31'h0, ok});
         if (!ok)
            end_sim;
         settle;
         chk("ready", 32'h0, {31'h0, req_ready});
         wr(`OFS_ACT_OPTS, 32'hFFFF_FFFF);
         rd(`OFS_ACT_OPTS, ex, "options");
         cmd_cyc.delete();
         cmd_addr.delete();
         u_far.fetch(3, ok);
         chk("reads", 32'h1, {31'h0, ok});
         if (!ok)
            end_sim;
         for (int k = 1; k < 3; k++)
            chk("gap", 32'(gaps[s]), 32'(cmd_cyc[k]-cmd_cyc[k-1]));
         for (int k = 0; k < 3; k++)
            chk("addr", r.src_addr + (cm ? 0 : 4 * k), cmd_addr[k]);
      end
   endtask : t_pace

   initial
   begin
      pclk       = 1'b0;
      presetn    = 1'b0;
      clk_en     = 1'b1;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = '0;
      pwdata     = '0;
      n_fail     = 0;
      num_checks = 0;
      cyc        = 0;
      irq_cnt    = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_errs;
      t_codes;
      t_pace;
      end_sim;
   end
endmodule : tb_top
